// File: hdl/scd_cfg.svh
// Purpose: constants for the system clock divider
// Assumes: included by design files by bare name
// Notes:   register map, reset value and timing counts
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH
`define SCD_ADDR_WCC        8'hc2
`define SCD_ADDR_STAT       8'hc3
`define SCD_WCC_RESET       8'hc8
`define SCD_WCC_FIXED_MASK  8'hc0
`define SCD_BIT_HALVE       5
`define SCD_BIT_RSVD4       4
`define SCD_CLK_MHZ         125
`define SCD_DUTY_MIN_MHZ    5
`define SCD_SETTLE_US       500
`define SCD_SETTLE_CYC      (`SCD_SETTLE_US * `SCD_CLK_MHZ)
`define SCD_PRE_W           12
`endif

// File: hdl/scd_pkg.sv
// Purpose: types for the system clock divider
// Assumes: constants live in scd_cfg.svh
// Notes:   none
package scd_pkg;
  typedef logic [7:0]  scd_byte_t;
  typedef logic [11:0] scd_taps_t;
  typedef enum logic [0:0] {
    SCD_SETTLING = 1'b0,
    SCD_STABLE   = 1'b1
  } scd_settle_e;
endpackage

// File: hdl/scd_prescaler.sv
// Purpose: free-running power-of-two prescaler
// Assumes: advance is a one-cycle enable per module clock tick
// Notes:   bit k of taps toggles at module clock / 2^(k+1)
`timescale 1ns/1ns
`include "scd_cfg.svh"
module scd_prescaler
(
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // control
  input  wire logic          advance,
  // taps
  output scd_pkg::scd_taps_t taps
);
  import scd_pkg::*;

  scd_taps_t cnt_q;
  scd_taps_t cnt_d;

  // counter step on each module clock tick
  always_comb
  begin
    cnt_d = cnt_q;
    if (advance)
      cnt_d = cnt_q + 12'h001;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 12'h000;
    else
      cnt_q <= cnt_d;
  end

  assign taps = cnt_q;
endmodule

// File: hdl/scd_top.sv
// Purpose: system clock divider with wait and clock control register
// Assumes: clk_sys is the oscillator clock after duty adjustment
// Notes:   module clock is expressed as a tick enable plus a toggle
// Operation
// - system clock runs at the oscillator input frequency, unmultiplied
// - halving select 0 gives undivided module clock; reset value 0
// - halving select 1 gives module clock at half system clock
// - register loads 0xc8 on hardware reset or hardware standby
// - software standby leaves register contents unchanged
// - two top bits ignore writes and read as one
// - bit 4 is reserved storage, readable and writable, reset zero
// - wait mode and wait count stored and forwarded to wait logic
// - duty correction applies at 5 MHz or higher
// - prescaler taps from module clock/2 down to /4096
// - clock output treated fixed only after settling delay elapsed
`timescale 1ns/1ns
`include "scd_cfg.svh"
module scd_top
#(
  parameter int unsigned SETTLE_CYC = `SCD_SETTLE_CYC
)
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // standby controls from the power manager (pins, synchronised here)
  input  wire logic                hw_standby,
  input  wire logic                sw_standby,
  // register port
  input  wire logic [7:0]          reg_addr,
  input  wire scd_pkg::scd_byte_t  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output scd_pkg::scd_byte_t       reg_rdata,
  // clock outputs
  output logic                     mod_clk_tick,
  output logic                     mod_clk_level,
  output scd_pkg::scd_taps_t       prescale_taps,
  output logic                     clock_stable,
  output logic                     duty_fix_on,
  // wait-state fields
  output logic [1:0]               wait_mode_sel,
  output logic [1:0]               wait_count
);
  import scd_pkg::*;

  localparam int unsigned CNT_W = 17;

  // standby synchronisers
  logic hws_m_q;
  logic hws_q;
  logic sws_m_q;
  logic sws_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hws_m_q <= 1'b0;
      hws_q   <= 1'b0;
      sws_m_q <= 1'b0;
      sws_q   <= 1'b0;
    end
    else
    begin
      hws_m_q <= hw_standby;
      hws_q   <= hws_m_q;
      sws_m_q <= sw_standby;
      sws_q   <= sws_m_q;
    end
  end

  // wait and clock control register
  scd_byte_t wcc_q;
  scd_byte_t wcc_d;

  // hardware standby outranks a write in the same cycle
  always_comb
  begin
    wcc_d = wcc_q;
    if (hws_q)
      wcc_d = `SCD_WCC_RESET;
    else if (reg_wr && reg_addr == `SCD_ADDR_WCC)
      wcc_d = reg_wdata | `SCD_WCC_FIXED_MASK;
    // software standby has no branch: contents kept
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      wcc_q <= `SCD_WCC_RESET;
    else
      wcc_q <= wcc_d;
  end

  // module clock generation: tick every cycle or every other cycle
  logic half_q;
  logic half_d;
  logic tick_q;
  logic tick_d;
  logic lvl_q;
  logic lvl_d;
  logic halve;

  assign halve = wcc_q[`SCD_BIT_HALVE];

  always_comb
  begin
    half_d = halve ? ~half_q : 1'b0;
    tick_d = 1'b1;
    if (halve)
      tick_d = half_q;
    lvl_d = tick_d ? ~lvl_q : lvl_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_q <= 1'b0;
      tick_q <= 1'b0;
      lvl_q  <= 1'b0;
    end
    else
    begin
      half_q <= half_d;
      tick_q <= tick_d;
      lvl_q  <= lvl_d;
    end
  end

  // prescaler on module clock ticks
  scd_taps_t taps_w;

  scd_prescaler u_pre (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .advance (tick_q),
    .taps    (taps_w)
  );

  // settling delay: clock not trusted until count elapses
  logic [CNT_W-1:0] settle_q;
  logic [CNT_W-1:0] settle_d;
  scd_settle_e      st_q;
  scd_settle_e      st_d;

  always_comb
  begin
    settle_d = settle_q;
    st_d     = st_q;
    case (st_q)
      SCD_SETTLING:
      begin
        if (settle_q >= CNT_W'(SETTLE_CYC - 1))
          st_d = SCD_STABLE;
        else
          settle_d = settle_q + CNT_W'(1);
      end
      SCD_STABLE:
      begin
        st_d = SCD_STABLE;
      end
      default:
      begin
        st_d = SCD_SETTLING;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settle_q <= '0;
      st_q     <= SCD_SETTLING;
    end
    else
    begin
      settle_q <= settle_d;
      st_q     <= st_d;
    end
  end

  // read data and registered outputs
  scd_byte_t rdata_q;
  scd_byte_t rdata_d;

  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd && reg_addr == `SCD_ADDR_WCC)
      rdata_d = wcc_q | `SCD_WCC_FIXED_MASK;
    else if (reg_rd && reg_addr == `SCD_ADDR_STAT)
      rdata_d = {6'h00, sws_q, st_q == SCD_STABLE};
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q      <= 8'h00;
      clock_stable <= 1'b0;
      duty_fix_on  <= 1'b0;
      wait_mode_sel <= 2'h2;
      wait_count   <= 2'h0;
      prescale_taps <= 12'h000;
    end
    else
    begin
      rdata_q       <= rdata_d;
      clock_stable  <= (st_q == SCD_STABLE);
      duty_fix_on   <= (`SCD_CLK_MHZ >= `SCD_DUTY_MIN_MHZ);
      wait_mode_sel <= wcc_q[3:2];
      wait_count    <= wcc_q[1:0];
      prescale_taps <= taps_w;
    end
  end

  // outputs straight from their flip-flops; clk_sys itself is the system
  // clock, passed on at the oscillator rate with no multiply or divide,
  // so every tick and tap here counts whole oscillator cycles
  assign reg_rdata     = rdata_q;
  assign mod_clk_tick  = tick_q;
  assign mod_clk_level = lvl_q;

  // helper: cycles since reset release, for the settling check
  logic [CNT_W-1:0] age_q;
  logic [CNT_W-1:0] age_d;

  always_comb
  begin
    age_d = age_q;
    if (age_q != {CNT_W{1'b1}})
      age_d = age_q + CNT_W'(1);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      age_q <= '0;
    else
      age_q <= age_d;
  end

  // checks
  a_top_bits_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wcc_q[7:6] == 2'h3) else $error("top bits not one");
  a_hws_loads: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hws_q |=> wcc_q == `SCD_WCC_RESET) else $error("standby load failed");
  a_write_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && reg_addr == `SCD_ADDR_WCC && !hws_q)
    |=> wcc_q[5:0] == $past(reg_wdata[5:0])) else $error("write lost");
  a_sws_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sws_q && !hws_q && !reg_wr) |=> $stable(wcc_q)) else $error("sw standby change");
  a_full_rate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !halve [*2] |=> tick_q) else $error("undivided tick missing");
  a_half_rate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (halve && tick_q && $past(halve)) |=> !tick_q) else $error("halved tick");
  a_wait_fwd: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> wait_count == $past(wcc_q[1:0])) else $error("wait count");
  a_pre_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick_q |=> taps_w == $past(taps_w) + 12'h001) else $error("prescaler step");
  a_not_early: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == SCD_STABLE) |-> settle_q >= CNT_W'(SETTLE_CYC - 1))
    else $error("stable too early");

  // forwarding, read and register hold checks
  a_mode_fwd: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> wait_mode_sel == $past(wcc_q[3:2])) else $error("wait mode");
  a_taps_fwd: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> prescale_taps == $past(taps_w)) else $error("taps output");
  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
  a_rd_fixed: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && reg_addr == `SCD_ADDR_WCC) |=> reg_rdata[7:6] == 2'h3) else $error("top bits read");
  a_regs_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!hws_q && !(reg_wr && reg_addr == `SCD_ADDR_WCC)) |=> $stable(wcc_q))
    else $error("register changed unasked");

  // module clock, duty fix and settling checks
  a_level_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(lvl_q) == tick_q) else $error("level step");
  a_pre_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !tick_q |=> taps_w == $past(taps_w)) else $error("prescaler moved");
  a_duty_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> duty_fix_on) else $error("duty fix off");
  a_stable_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clock_stable |=> clock_stable) else $error("stable dropped");
  a_settle_exact: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(clock_stable) |-> age_q == CNT_W'(SETTLE_CYC + 1))
    else $error("settle time wrong");

  // scenario covers
  c_halve_on: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(halve));
  c_stable: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(clock_stable));
  c_hws: cover property (@(posedge clk_sys) disable iff (!rst_n) hws_q);
  c_half_tick: cover property (@(posedge clk_sys) disable iff (!rst_n) halve && tick_q);
  c_sws: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(sws_q));
endmodule

// File: sim/scd_clk_src.sv
// Purpose: external clock source and reset supervisor model
// Assumes: 125 MHz oscillator that runs free, as a crystal would
// Notes:   reset window shortened along with the settle count
`timescale 1ns/1ns
module scd_clk_src
(
  // oscillator
  output logic clk_sys,
  // reset
  output logic rst_n
);
  // oscillator at the system rate, nothing multiplied
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // reset low for 20 cycles, well over the 10 cycle pulse
  initial
  begin
    rst_n = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
  end
endmodule

// File: sim/system_clock_divider_tb_top.sv
// Purpose: register and module clock checks for the clock divider
// Assumes: clock source model drives clk_sys and rst_n
// Notes:   settle count cut to 20 cycles to keep the run short
`timescale 1ns/1ns
`include "scd_cfg.svh"
module system_clock_divider_tb_top;
  import scd_pkg::*;
  logic       clk_sys;
  logic       rst_n;
  logic       hw_standby = 1'b0;
  logic       sw_standby = 1'b0;
  logic [7:0] reg_addr   = 8'h00;
  scd_byte_t  reg_wdata  = 8'h00;
  logic       reg_wr     = 1'b0;
  logic       reg_rd     = 1'b0;
  scd_byte_t  reg_rdata;
  logic       mod_clk_tick;
  logic       mod_clk_level;
  scd_taps_t  prescale_taps;
  logic       clock_stable;
  logic       duty_fix_on;
  logic [1:0] wait_mode_sel;
  logic [1:0] wait_count;
  int         num_errors = 0;
  int         samples_checked = 0;

  scd_clk_src u_src (.clk_sys(clk_sys), .rst_n(rst_n));

  scd_top #(.SETTLE_CYC(20)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mod_clk_tick(mod_clk_tick), .mod_clk_level(mod_clk_level),
    .prescale_taps(prescale_taps), .clock_stable(clock_stable),
    .duty_fix_on(duty_fix_on), .wait_mode_sel(wait_mode_sel),
    .wait_count(wait_count));

  // compare and count
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
    samples_checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input scd_byte_t d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rchk(input string nm, input logic [7:0] a, input scd_byte_t e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk(nm, {4'h0, e}, {4'h0, reg_rdata});
  endtask

  // ticks, level steps and prescaler advance over an 8 cycle window
  task automatic clkchk(input int ticks);
    int        n;
    int        steps;
    logic      lv;
    scd_taps_t t0;
    n = 0;
    steps = 0;
    #1;
    t0 = prescale_taps;
    lv = mod_clk_level;
    repeat (8)
    begin
      @(posedge clk_sys);
      #1;
      n += (mod_clk_tick === 1'b1);
      steps += (mod_clk_level !== lv);
      lv = mod_clk_level;
    end
    chk("ticks", ticks[11:0], n[11:0]);
    chk("level", ticks[11:0], steps[11:0]);
    chk("taps", t0 + ticks[11:0], prescale_taps);
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence; a clock_stable wait that times out skips ahead to the verdict, a reset wait timeout counts an error and carries on
  initial
  begin
    int i;
    for (i = 0; i < 100 && rst_n !== 1'b1; i++) @(posedge clk_sys);
    if (i == 100)
    begin
      num_errors++;
      $display("[FAIL] rst_n exp 1 got 0");
    end
    @(posedge clk_sys);
    #1;
    chk("stable_early", 12'h0, clock_stable);
    chk("duty_fix", 12'h1, duty_fix_on);
    chk("wms_rst", 12'h2, wait_mode_sel);
    chk("wc_rst", 12'h0, wait_count);
    rchk("wcc_rst", `SCD_ADDR_WCC, 8'hc8);
    for (i = 0; i < 100 && clock_stable !== 1'b1; i++) @(posedge clk_sys);
    if (i == 100)
    begin
      num_errors++;
      $display("[FAIL] clock_stable exp 1 got 0");
    end
    else
    begin
      rchk("stat", `SCD_ADDR_STAT, 8'h01);
      $display("test reset done");
      wr(`SCD_ADDR_WCC, 8'h3f);
      rchk("wcc_ones", `SCD_ADDR_WCC, 8'hff);
      chk("wms", 12'h3, wait_mode_sel);
      chk("wc", 12'h3, wait_count);
      wr(`SCD_ADDR_WCC, 8'h10);
      rchk("wcc_b4", `SCD_ADDR_WCC, 8'hd0);
      rchk("unmapped", 8'h00, 8'h00);
      $display("test register done");
      wr(`SCD_ADDR_WCC, 8'h00);
      repeat (2) @(posedge clk_sys);
      clkchk(8);
      wr(`SCD_ADDR_WCC, 8'h20);
      repeat (2) @(posedge clk_sys);
      clkchk(4);
      $display("test module clock done");
      wr(`SCD_ADDR_WCC, 8'h1b);
      sw_standby <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rchk("stat_sw", `SCD_ADDR_STAT, 8'h03);
      rchk("wcc_sw", `SCD_ADDR_WCC, 8'hdb);
      @(posedge clk_sys);
      sw_standby <= 1'b0;
      hw_standby <= 1'b1;
      repeat (3) @(posedge clk_sys);
      wr(`SCD_ADDR_WCC, 8'h3f);
      hw_standby <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rchk("wcc_hw", `SCD_ADDR_WCC, 8'hc8);
      chk("wms_hw", 12'h2, wait_mode_sel);
      $display("test standby done");
    end
    stop_test();
  end
endmodule
